// *** alie_pkg.sv ***
// Register map, field layout and bus constants for the converter control slice
package alie_pkg;

  // Address width seen by the register decoder
  localparam int unsigned ADDR_W = 12;
  // Number of converter channels
  localparam int unsigned NUM_CHAN = 8;
  // Number of analog input pins that a channel may select
  localparam int unsigned NUM_AIN = 8;
  // Number of interrupt-capable events
  localparam int unsigned EVT_W = 22;
  // Width of a pin selection field
  localparam int unsigned SEL_W = 4;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_IRQ_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_DISABLE_MASK = 12'h308;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h310;
  localparam logic [11:0] OFS_BUSY_FLAG = 12'h400;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  // Pin selection block: positive at base + n*stride, negative four bytes on
  localparam logic [11:0] OFS_PSEL_BASE = 12'h510;
  localparam logic [11:0] OFS_PSEL_STRIDE = 12'h010;
  localparam logic [11:0] OFS_PSEL_NEG_STEP = 12'h004;

  // Event bit layout: six lower events, then high/low limit pairs per channel
  localparam int unsigned LOWER_EVT_W = 6;
  localparam int unsigned HIGH_LIMIT_BASE = 6;
  localparam int unsigned LOW_LIMIT_BASE = 7;
  localparam int unsigned LIMIT_STEP = 2;

  // Reset values
  localparam logic [EVT_W-1:0] IRQ_ENABLE_RESET = 22'h000000;
  localparam logic [EVT_W-1:0] EVENT_STATUS_RESET = 22'h000000;
  localparam logic ENABLE_RESET = 1'h0;
  localparam logic [SEL_W-1:0] PSEL_RESET = 4'h0;
  // Selection value meaning not connected
  localparam logic [SEL_W-1:0] PSEL_NC = 4'h0;
  // Selection value of the first analog input pin
  localparam logic [SEL_W-1:0] PSEL_AIN_FIRST = 4'h1;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : alie_pkg

// *** alie_converter_ctrl.sv ***
// Converter control slice: interrupt enables, busy status, enable and pin claim
//
// Summary of operation
// - Writing one disables a channel high-limit interrupt
// - Writing one disables a channel low-limit interrupt
// - Busy flag reads zero while converter idle
// - Busy flag reads one during conversion
// - Enable bit switches converter, resets to zero
// - Enabled converter claims selected analog input pins
// - Same register disables lower events in low bits
// - Negative select zero means single-ended channel
//
// Register access over AXI4-Lite was left to the implementer.
module alie_converter_ctrl
  import alie_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter engine side
  input wire logic conv_busy,
  input wire logic [EVT_W-1:0] event_pulse,
  output logic conv_enable,
  output logic [NUM_AIN-1:0] ain_claim,
  output logic [NUM_CHAN-1:0] chan_differential,
  // Interrupt
  output logic irq
);

  // Interrupt enables, one per event
  logic [EVT_W-1:0] irq_enable;
  // Sticky event flags
  logic [EVT_W-1:0] event_status;
  // Per channel pin selections
  logic [SEL_W-1:0] psel_pos [NUM_CHAN];
  logic [SEL_W-1:0] psel_neg [NUM_CHAN];
  // Write path decode
  logic wr_fire;
  logic [31:0] wr_bits;
  logic wr_hit;
  // Read path decode
  logic rd_fire;
  logic [31:0] next_rdata;
  logic rd_hit;
  // Pin claims gathered per channel
  logic [NUM_AIN-1:0] chan_claim [NUM_CHAN];

  // Both write channels are taken together, only while no response waits
  assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  // One read in flight at a time
  assign rd_fire = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_fire;

  // Byte strobes gate which data bits take effect
  assign wr_bits = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // Write decode; pin selection words are matched inside the channel loop
  always_comb begin
    wr_hit = 1'b0;
    if (s_axi_awaddr == OFS_IRQ_ENABLE_SET || s_axi_awaddr == OFS_IRQ_DISABLE_MASK ||
        s_axi_awaddr == OFS_EVENT_STATUS || s_axi_awaddr == OFS_BUSY_FLAG ||
        s_axi_awaddr == OFS_ENABLE) begin
      wr_hit = 1'b1;
    end
    for (int n = 0; n < NUM_CHAN; n++) begin
      if (s_axi_awaddr == OFS_PSEL_BASE + OFS_PSEL_STRIDE * n[11:0] ||
          s_axi_awaddr == OFS_PSEL_BASE + OFS_PSEL_STRIDE * n[11:0] + OFS_PSEL_NEG_STEP) begin
        wr_hit = 1'b1;
      end
    end
  end

  // Write response; read-only busy word accepts writes silently
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      // Response taken
      s_axi_bvalid <= 1'b0;
    end
  end

  // Interrupt enables: set word raises, disable word lowers, zeros keep
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_enable <= IRQ_ENABLE_RESET;
    end else if (wr_fire && s_axi_awaddr == OFS_IRQ_ENABLE_SET) begin
      irq_enable <= irq_enable | wr_bits[EVT_W-1:0];
    end else if (wr_fire && s_axi_awaddr == OFS_IRQ_DISABLE_MASK) begin
      // Covers lower events and every limit event alike
      irq_enable <= irq_enable & ~wr_bits[EVT_W-1:0];
    end
  end

  // Sticky event flags; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      event_status <= EVENT_STATUS_RESET;
    end else if (wr_fire && s_axi_awaddr == OFS_EVENT_STATUS) begin
      event_status <= (event_status & ~wr_bits[EVT_W-1:0]) | event_pulse;
    end else begin
      event_status <= event_status | event_pulse;
    end
  end

  // Level interrupt from any enabled, pending event
  assign irq = |(event_status & irq_enable);

  // Peripheral enable bit
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      conv_enable <= ENABLE_RESET;
    end else if (wr_fire && s_axi_awaddr == OFS_ENABLE && s_axi_wstrb[0]) begin
      conv_enable <= s_axi_wdata[0];
    end
  end

  // Per channel selection registers and pin claim
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
      // Byte addresses of this channel's two selection words
      // Cast on purpose: the genvar product is 32 bits, the address map only 12
      localparam logic [11:0] POS_ADDR = 12'(OFS_PSEL_BASE + OFS_PSEL_STRIDE * gc);
      localparam logic [11:0] NEG_ADDR = POS_ADDR + OFS_PSEL_NEG_STEP;

      // Positive input selection
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          psel_pos[gc] <= PSEL_RESET;
        end else if (wr_fire && s_axi_awaddr == POS_ADDR && s_axi_wstrb[0]) begin
          psel_pos[gc] <= s_axi_wdata[SEL_W-1:0];
        end
      end

      // Negative input selection
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          psel_neg[gc] <= PSEL_RESET;
        end else if (wr_fire && s_axi_awaddr == NEG_ADDR && s_axi_wstrb[0]) begin
          psel_neg[gc] <= s_axi_wdata[SEL_W-1:0];
        end
      end

      // Differential only when a negative input is chosen
      assign chan_differential[gc] = conv_enable && (psel_neg[gc] != PSEL_NC);

      // Pins named by this channel; supply selections name no pin
      always_comb begin
        chan_claim[gc] = '0;
        for (int k = 0; k < NUM_AIN; k++) begin
          if (psel_pos[gc] == PSEL_AIN_FIRST + k[SEL_W-1:0] ||
              psel_neg[gc] == PSEL_AIN_FIRST + k[SEL_W-1:0]) begin
            chan_claim[gc][k] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // Pins are handed over only while the converter is on
  always_comb begin
    ain_claim = '0;
    for (int n = 0; n < NUM_CHAN; n++) begin
      ain_claim = ain_claim | chan_claim[n];
    end
    if (!conv_enable) begin
      ain_claim = '0;
    end
  end

  // Read mux; busy comes straight from the engine, not from a copy
  always_comb begin
    next_rdata = 32'h0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      OFS_IRQ_ENABLE_SET, OFS_IRQ_DISABLE_MASK: begin
        next_rdata[EVT_W-1:0] = irq_enable;
      end
      OFS_EVENT_STATUS: begin
        next_rdata[EVT_W-1:0] = event_status;
      end
      OFS_BUSY_FLAG: begin
        next_rdata[0] = conv_busy;
      end
      OFS_ENABLE: begin
        next_rdata[0] = conv_enable;
      end
      default: begin
        // Selection words or an unmapped address
        rd_hit = 1'b0;
        for (int n = 0; n < NUM_CHAN; n++) begin
          if (s_axi_araddr == OFS_PSEL_BASE + OFS_PSEL_STRIDE * n[11:0]) begin
            next_rdata[SEL_W-1:0] = psel_pos[n];
            rd_hit = 1'b1;
          end
          if (s_axi_araddr == OFS_PSEL_BASE + OFS_PSEL_STRIDE * n[11:0] + OFS_PSEL_NEG_STEP) begin
            next_rdata[SEL_W-1:0] = psel_neg[n];
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // Read data registered one cycle after the address is taken
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      // Data taken
      s_axi_rvalid <= 1'b0;
    end
  end

  // Assertions

  // Helper: a write to the disable word in the previous cycle
  logic dis_wr_q;
  logic [EVT_W-1:0] dis_bits_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dis_wr_q <= 1'b0;
      dis_bits_q <= '0;
    end else begin
      dis_wr_q <= wr_fire && s_axi_awaddr == OFS_IRQ_DISABLE_MASK;
      dis_bits_q <= wr_bits[EVT_W-1:0];
    end
  end

  // Helper: limit event bit masks built from the package layout
  // Derived rather than typed in, so a layout change cannot leave them stale
  logic [EVT_W-1:0] high_mask;
  logic [EVT_W-1:0] low_mask;
  always_comb begin
    high_mask = '0;
    low_mask = '0;
    for (int n = 0; n < NUM_CHAN; n++) begin
      // High limit at base + step*n, low limit one bit above
      high_mask[HIGH_LIMIT_BASE + LIMIT_STEP * n] = 1'b1;
      low_mask[LOW_LIMIT_BASE + LIMIT_STEP * n] = 1'b1;
    end
  end

  a_high_disable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    dis_wr_q |-> (irq_enable & dis_bits_q & high_mask) == '0)
    else $error("high limit enable survived a disable write");

  a_low_disable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    dis_wr_q |-> (irq_enable & dis_bits_q & low_mask) == '0)
    else $error("low limit enable survived a disable write");

  a_busy_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_fire && s_axi_araddr == OFS_BUSY_FLAG && !conv_busy) |=> s_axi_rdata == 32'h0)
    else $error("busy flag read nonzero while idle");

  a_busy_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_fire && s_axi_araddr == OFS_BUSY_FLAG && conv_busy) |=> s_axi_rdata == 32'h1)
    else $error("busy flag read wrong during conversion");

  a_enable_reset: assert property (@(posedge ref_clk)
    !reset_n |=> !conv_enable)
    else $error("enable not zero after reset");

  a_enable_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_fire && s_axi_awaddr == OFS_ENABLE && s_axi_wstrb[0]) |=>
      conv_enable == $past(s_axi_wdata[0]))
    else $error("enable did not follow write");

  a_pin_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !conv_enable |-> ain_claim == '0 && chan_differential == '0)
    else $error("pins claimed while disabled");

  a_lower_disable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    dis_wr_q |-> (irq_enable[LOWER_EVT_W-1:0] & dis_bits_q[LOWER_EVT_W-1:0]) == '0)
    else $error("lower event enable survived a disable write");

  a_single_ended: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (conv_enable && psel_neg[0] == PSEL_NC) |-> !chan_differential[0])
    else $error("channel zero differential with no negative input");

  // Positive side of the pin hand-over: first pin named by channel one
  a_pin_claim: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (conv_enable && psel_pos[1] == PSEL_AIN_FIRST) |-> ain_claim[0])
    else $error("selected pin not claimed while enabled");

  // A chosen negative input makes the channel differential
  a_diff_select: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (conv_enable && psel_neg[1] != PSEL_NC) |-> chan_differential[1])
    else $error("channel one not differential with a negative input");

  a_zero_keeps: assert property (@(posedge ref_clk) disable iff (!reset_n)
    dis_wr_q |-> (irq_enable & ~dis_bits_q) == ($past(irq_enable) & ~dis_bits_q))
    else $error("disable write changed an enable written as zero");

  // A disable write in the same cycle may lawfully drop the enable
  a_irq_pending: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ((|(event_pulse & irq_enable)) && !(wr_fire && s_axi_awaddr == OFS_IRQ_DISABLE_MASK))
      |=> irq)
    else $error("enabled event did not raise the interrupt");

  // Main scenarios
  c_disable_write: cover property (@(posedge ref_clk) disable iff (!reset_n)
    wr_fire && s_axi_awaddr == OFS_IRQ_DISABLE_MASK && wr_bits[21]);
  c_busy_read: cover property (@(posedge ref_clk) disable iff (!reset_n)
    rd_fire && s_axi_araddr == OFS_BUSY_FLAG && conv_busy);
  c_pin_claim: cover property (@(posedge ref_clk) disable iff (!reset_n)
    conv_enable && ain_claim != '0);
  c_irq_raise: cover property (@(posedge ref_clk) disable iff (!reset_n)
    !irq ##1 irq);
  c_differential: cover property (@(posedge ref_clk) disable iff (!reset_n)
    chan_differential != '0);

endmodule : alie_converter_ctrl

// *** adc_limit_irq_status_enable_test.sv ***
// Self-checking register-level testbench for the converter control slice
module adc_limit_irq_status_enable_test;
  timeunit 1ns;
  timeprecision 1ps;
  import alie_pkg::*;

  // Clock, reset and bus signals
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // Engine side
  logic conv_busy = 1'b0;
  logic [EVT_W-1:0] event_pulse = '0;
  logic conv_enable, irq;
  logic [NUM_AIN-1:0] ain_claim;
  logic [NUM_CHAN-1:0] chan_differential;
  // Scoreboard counters
  int failures = 0;
  int checks = 0;
  // Expected interrupt enables
  logic [31:0] exp_en;

  alie_converter_ctrl DUT (
    .ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_busy,
    .event_pulse, .conv_enable, .ain_claim, .chan_differential, .irq
  );

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // Word comparison
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  // Response code comparison
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_resp

  // Verdict and end of run
  task automatic summarize;
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Write: address and data offered together, held until taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [1:0] er, input logic [3:0] st = 4'hf);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Decide at the falling edge, so the next rising edge is the taking one
    do begin @(negedge ref_clk); end while (s_axi_awready !== 1'b1);
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do begin @(negedge ref_clk); end while (s_axi_bvalid !== 1'b1);
    check_resp(s_axi_bresp, er);
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  // Read one word and compare it with its response code
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic [1:0] er = RESP_OKAY);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(negedge ref_clk); end while (s_axi_arready !== 1'b1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do begin @(negedge ref_clk); end while (s_axi_rvalid !== 1'b1);
    // Data stands until the edge where rready is seen high
    check_word(s_axi_rdata, exp);
    check_resp(s_axi_rresp, er);
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask : rd_chk

  // One-cycle event from the engine
  task automatic fire_event(input int b);
    @(posedge ref_clk);
    event_pulse <= EVT_W'(1) << b;
    @(posedge ref_clk);
    event_pulse <= '0;
    repeat (2) @(posedge ref_clk);
  endtask : fire_event

  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #200000;
    failures++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values
    rd_chk(OFS_ENABLE, 32'h00000000);
    rd_chk(OFS_IRQ_DISABLE_MASK, 32'h00000000);
    check_word({31'h0, conv_enable}, 32'h00000000);
    // Busy flag follows the engine; writes to it are ignored
    rd_chk(OFS_BUSY_FLAG, 32'h00000000);
    @(posedge ref_clk);
    conv_busy <= 1'b1;
    rd_chk(OFS_BUSY_FLAG, 32'h00000001);
    @(posedge ref_clk);
    conv_busy <= 1'b0;
    axi_write(OFS_BUSY_FLAG, 32'h00000001, RESP_OKAY);
    rd_chk(OFS_BUSY_FLAG, 32'h00000000);
    // Enable every event, then a zero write changes nothing
    exp_en = 32'h003fffff;
    axi_write(OFS_IRQ_ENABLE_SET, exp_en, RESP_OKAY);
    axi_write(OFS_IRQ_DISABLE_MASK, 32'h00000000, RESP_OKAY);
    rd_chk(OFS_IRQ_DISABLE_MASK, exp_en);
    // Disable one bit at a time; the others must hold
    for (int b = 0; b < EVT_W; b++) begin
      exp_en[b] = 1'b0;
      axi_write(OFS_IRQ_DISABLE_MASK, 32'h1 << b, RESP_OKAY);
      rd_chk(OFS_IRQ_DISABLE_MASK, exp_en);
    end
    // Channel 3 low-limit event drives the interrupt only while enabled
    axi_write(OFS_IRQ_ENABLE_SET, 32'h00002000, RESP_OKAY);
    fire_event(13);
    check_word({31'h0, irq}, 32'h00000001);
    axi_write(OFS_IRQ_DISABLE_MASK, 32'h00002000, RESP_OKAY);
    check_word({31'h0, irq}, 32'h00000000);
    // Channel 4 high-limit event while disabled: status only
    fire_event(14);
    check_word({31'h0, irq}, 32'h00000000);
    rd_chk(OFS_EVENT_STATUS, 32'h00006000);
    axi_write(OFS_IRQ_ENABLE_SET, 32'h00004000, RESP_OKAY);
    check_word({31'h0, irq}, 32'h00000001);
    axi_write(OFS_EVENT_STATUS, 32'h00006000, RESP_OKAY);
    check_word({31'h0, irq}, 32'h00000000);
    rd_chk(OFS_EVENT_STATUS, 32'h00000000);
    // Pin selections: ch0 positive AIN2, ch1 positive AIN0, ch1 negative AIN7
    axi_write(OFS_PSEL_BASE, 32'h00000003, RESP_OKAY);
    axi_write(12'h520, 32'h00000001, RESP_OKAY);
    axi_write(12'h524, 32'h00000008, RESP_OKAY);
    check_word({24'h0, ain_claim}, 32'h00000000);
    check_word({24'h0, chan_differential}, 32'h00000000);
    axi_write(OFS_ENABLE, 32'h00000001, RESP_OKAY);
    rd_chk(OFS_ENABLE, 32'h00000001);
    check_word({31'h0, conv_enable}, 32'h00000001);
    check_word({24'h0, ain_claim}, 32'h00000085);
    check_word({24'h0, chan_differential}, 32'h00000002);
    axi_write(OFS_ENABLE, 32'h00000000, RESP_OKAY);
    check_word({31'h0, conv_enable}, 32'h00000000);
    check_word({24'h0, ain_claim}, 32'h00000000);
    // Enable write with its lowest byte lane masked leaves the bit off
    axi_write(OFS_ENABLE, 32'h00000001, RESP_OKAY, 4'he);
    rd_chk(OFS_ENABLE, 32'h00000000);
    // Unmapped place is refused
    rd_chk(12'h518, 32'h00000000, RESP_SLVERR);
    axi_write(12'h518, 32'h00000001, RESP_SLVERR);
    summarize();
  end

endmodule : adc_limit_irq_status_enable_test
